// *** include/spi_chan_pkg.sv ***
// Constants and carrier types shared by the SPI serial channel
package spi_chan_pkg;
   // Mode field encodings and character length
   localparam logic [1:0] MODE_MASTER  = 2'b10;
   localparam logic [1:0] MODE_SLAVE   = 2'b11;
   localparam logic [1:0] WLS_8BIT     = 2'b11;
   // Timing: SPI clock half period in master mode
   localparam int CLK_PERIOD_NS = 25;
   localparam int SPI_HALF_NS   = 100;
   localparam int SPI_HALF_CYC  = (SPI_HALF_NS / CLK_PERIOD_NS < 1) ? 1
                                  : SPI_HALF_NS / CLK_PERIOD_NS;
   localparam int DIV_W         = 4;
   // FIFO geometry: 32 bytes each way, receive side held as 4-byte words
   localparam int TXF_DEPTH     = 32;
   localparam int TXF_AW        = 5;
   localparam int TXF_CW        = 6;
   localparam int BYTES_PER_WORD = 4;
   localparam int RXF_DEPTH     = 8;
   localparam int RXF_AW        = 3;
   localparam int RXF_CW        = 4;
   localparam int GAP_W         = 16;
   // Byte shifted out when the slave has nothing queued
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   // Receive DMA channel serving each serial channel
   localparam int RX_DMA_CHAN1  = 7;
   localparam int RX_DMA_CHAN2  = 9;
   localparam logic [2:0] MAX_BYTES = 3'h4;

   typedef struct packed {
      logic       sclk;
      logic       sel_b;
      logic       rxd;
   } spi_in_t;

   typedef struct packed {
      logic [2:0]  count;
      logic [31:0] data;
   } rx_entry_t;

   typedef enum {M_IDLE, M_LOW, M_HIGH} link_state_t;
endpackage

// *** hw/spi_pin_sync.sv ***
// Two-flop synchroniser for pins arriving from outside the core clock domain
`timescale 1ns/100ps
module spi_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // spi_pin_sync

// *** hw/spi_serial_channel.sv ***
// SPI serial channel: TX FIFO, master/slave link, RX packing, gap timers, RX FIFO drain
// Behaviour
// RQ1: With ready high, one 32-bit read returns a word of one to four bytes.
// RQ2: Valid byte count of the next word is shown before the data is read.
// RQ3: Buffer close sets a flag; reads refused until a one is written back.
// RQ4: Interrupt from ready or closed when local and global enables are set.
// RQ5: DMA mode requests receive service; channel 7 or 9, interrupts off.
// RQ6: Software sets mode 10 for master before enabling the channel.
// RQ7: Software sets mode 11 for slave before enabling the channel.
// RQ8: Clearing the channel enable resets the whole channel and FIFOs; the code leaves rx_data holding its last word.
// RQ9: Software sets 1x, non-inverted timing, internal or external source.
// RQ10: Software selects eight-bit characters for SPI.
// RQ11: Buffer gap timer ends transfer a set time after first character.
// RQ12: Character gap timer ends transfer when characters are too far apart.
// RQ13: Master changes data on falling clock while select low.
// RQ14: Master select falls with first bit's falling edge, rises after eighth rise.
// RQ15: Master never raises the clock while select is high.
// RQ16: Master sends while TX FIFO holds data, else select stays high.
// RQ17: Data input sampled on rising clock only while select low.
// RQ18: Slave samples three to four core clocks after each rising clock.
// RQ19: Master receives exactly one byte per byte sent.
// RQ20: Received bytes enter the RX FIFO as full four-byte words, except when a gap timer flush pushes residual bytes.
// RQ21: Gap timer expiry pushes residual bytes into the RX FIFO at once.
// RQ22: Slave presents first bit early, advances 3-4 clocks after rising edge.
// RQ23: 32-byte receive and transmit FIFOs.
// RQ24: Each data read advances the RX FIFO by one whole word.
// RQ25: Slave data output holds still while select is high, once the first bit is loaded.
`timescale 1ns/100ps
module spi_serial_channel (
   input  wire logic                     core_clk,
   input  wire logic                     rst_b,
   input  wire logic                     chan_enable,
   input  wire logic [1:0]               mode,
   input  wire logic [1:0]               word_length_select,
   input  wire logic                     bit_order_select,
   input  wire logic                     rx_ready_irq_enable,
   input  wire logic                     rx_closed_irq_enable,
   input  wire logic                     chan_rx_global_irq_en,
   input  wire logic                     rx_dma_enable,
   input  wire logic                     buffer_gap_timer_enable,
   input  wire logic                     char_gap_timer_enable,
   input  wire logic [15:0]              buffer_gap_limit,
   input  wire logic [15:0]              char_gap_limit,
   input  wire logic                     tx_valid,
   input  wire logic [7:0]               tx_byte,
   input  wire logic                     rx_read,
   input  wire logic                     closed_ack,
   input  wire spi_chan_pkg::spi_in_t    spi_in,
   output logic                          tx_ready,
   output logic [31:0]                   rx_data,
   output logic                          rx_ready_flag,
   output logic [2:0]                    rx_valid_byte_count,
   output logic                          rx_buffer_closed,
   output logic                          rx_irq,
   output logic                          rx_dma_req,
   output logic                          sclk_out,
   output logic                          sclk_oe,
   output logic                          sel_b_out,
   output logic                          sel_b_oe,
   output logic                          txd_out,
   output logic                          txd_oe
);
   import spi_chan_pkg::*;

   logic run, is_mst, is_slv;
   spi_in_t pin_s;

   // Channel only runs with enable set in an SPI mode; enable low is the channel reset
   assign run    = chan_enable & mode[1] & (word_length_select == WLS_8BIT); // RQ8
   assign is_mst = run & (mode == MODE_MASTER);
   assign is_slv = run & (mode == MODE_SLAVE);

   // All link pins pass two flops before use
   spi_pin_sync #(.WIDTH(3)) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .d        (spi_in),
      .q        (pin_s)
   );

   // ---------------- Transmit FIFO ----------------
   logic [7:0]        tx_mem [TXF_DEPTH];
   logic [TXF_AW-1:0] tx_wp, tx_rp, next_tx_wp, next_tx_rp;
   logic [TXF_CW-1:0] tx_cnt, next_tx_cnt;
   logic              tx_push, tx_pop, tx_has, next_tx_ready;
   logic [7:0]        tx_head;

   assign tx_has  = (tx_cnt != '0);
   assign tx_head = tx_mem[tx_rp];

   // Ready is computed from the next count so the producer never overfills
   always_comb begin
      tx_push     = tx_valid & tx_ready;
      next_tx_wp  = tx_wp + TXF_AW'(tx_push);
      next_tx_rp  = tx_rp + TXF_AW'(tx_pop);
      next_tx_cnt = tx_cnt + TXF_CW'(tx_push) - TXF_CW'(tx_pop);
      if (!run) begin
         next_tx_wp  = '0;
         next_tx_rp  = '0;
         next_tx_cnt = '0;
      end
      next_tx_ready = run & (next_tx_cnt != TXF_CW'(TXF_DEPTH)); // RQ23
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tx_wp    <= '0;
         tx_rp    <= '0;
         tx_cnt   <= '0;
         tx_ready <= 1'b0;
      end else begin
         tx_wp    <= next_tx_wp;
         tx_rp    <= next_tx_rp;
         tx_cnt   <= next_tx_cnt;
         tx_ready <= next_tx_ready;
      end
   end

   // Storage has no reset; pointers decide what is valid
   always_ff @(posedge core_clk) begin
      if (tx_push) begin
         tx_mem[tx_wp] <= tx_byte;
      end
   end

   // ---------------- Link: master clock/select, slave tracking ----------------
   link_state_t      lstate, next_lstate;
   logic [DIV_W-1:0] div_cnt, next_div;
   logic [2:0]       bit_cnt, next_bits;
   logic [7:0]       tx_sh, next_sh, shifted;
   logic             sclk_d, sclk_d2, sl_need, next_need, tick, rx_sample, sclk_rise;
   logic             next_sclk, next_sel, next_txd;

   assign shifted   = bit_order_select ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
   assign tick      = (div_cnt == DIV_W'(SPI_HALF_CYC - 1));
   assign sclk_rise = sclk_d & ~sclk_d2; // RQ18

   // Master sends one byte per select-low window; sampling counts follow sending exactly
   always_comb begin
      next_lstate = lstate;
      next_div    = '0;
      next_bits   = bit_cnt;
      next_sh     = tx_sh;
      next_sclk   = 1'b1;
      next_sel    = 1'b1;
      next_need   = sl_need;
      tx_pop      = 1'b0;
      rx_sample   = 1'b0;
      if (is_mst) begin
         next_div  = tick ? '0 : div_cnt + DIV_W'(1);
         next_sclk = sclk_out;
         next_sel  = sel_b_out;
         unique case (lstate)
            M_IDLE: begin
               if (tick && tx_has) begin  // RQ16
                  next_sh     = tx_head;
                  tx_pop      = 1'b1;
                  next_sclk   = 1'b0;      // RQ13
                  next_sel    = 1'b0;      // RQ14
                  next_bits   = '0;
                  next_lstate = M_LOW;
               end
            end
            M_LOW: begin
               if (tick) begin
                  next_sclk   = 1'b1;      // RQ15
                  rx_sample   = 1'b1;      // RQ19
                  next_lstate = M_HIGH;
               end
            end
            M_HIGH: begin
               if (tick) begin
                  if (bit_cnt == 3'h7) begin
                     next_sel    = 1'b1;   // RQ14
                     next_lstate = M_IDLE;
                  end else begin
                     next_sclk   = 1'b0;   // RQ13
                     next_sh     = shifted;
                     next_bits   = bit_cnt + 3'h1;
                     next_lstate = M_LOW;
                  end
               end
            end
         endcase
      end else if (is_slv) begin
         next_lstate = M_IDLE;
         if (pin_s.sel_b) begin
            // First bit loaded only while empty, then held until select falls
            if (sl_need && tx_has) begin  // RQ22
               next_sh   = tx_head;
               tx_pop    = 1'b1;
               next_need = 1'b0;
               next_bits = '0;
            end
         end else if (sclk_rise) begin    // RQ18
            rx_sample = 1'b1;             // RQ17
            next_bits = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               next_sh   = tx_has ? tx_head : IDLE_BYTE;
               tx_pop    = tx_has;
               next_need = ~tx_has;
            end else begin
               next_sh = shifted;         // RQ22
            end
         end
      end else begin
         next_lstate = M_IDLE;
         next_bits   = '0;
         next_sh     = IDLE_BYTE;
         next_need   = 1'b1;
      end
      next_txd = bit_order_select ? next_sh[0] : next_sh[7];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         lstate    <= M_IDLE;
         div_cnt   <= '0;
         bit_cnt   <= '0;
         tx_sh     <= IDLE_BYTE;
         sclk_d    <= 1'b0;
         sclk_d2   <= 1'b0;
         sl_need   <= 1'b1;
         sclk_out  <= 1'b1;
         sel_b_out <= 1'b1;
         txd_out   <= 1'b1;
         sclk_oe   <= 1'b0;
         sel_b_oe  <= 1'b0;
         txd_oe    <= 1'b0;
      end else begin
         lstate    <= next_lstate;
         div_cnt   <= next_div;
         bit_cnt   <= next_bits;
         tx_sh     <= next_sh;
         sclk_d    <= pin_s.sclk;
         sclk_d2   <= sclk_d;        // Extra stage lands sampling 3-4 clocks after the pin edge
         sl_need   <= next_need;
         sclk_out  <= next_sclk;
         sel_b_out <= next_sel;
         txd_out   <= next_txd;
         sclk_oe   <= is_mst;
         sel_b_oe  <= is_mst;
         txd_oe    <= run;
      end
   end

   // ---------------- Receive packing and gap timers ----------------
   logic [7:0]       rx_sh, next_rx_sh, nb;
   logic [2:0]       rx_bits, next_rx_bits, pack_cnt, next_pack_cnt;
   logic [31:0]      pack, next_pack;
   logic             byte_done, rx_push, flush, buf_exp, chr_exp;
   rx_entry_t        push_entry;
   logic             buf_act, next_buf_act;
   logic [GAP_W-1:0] buf_cnt, next_buf_cnt, chr_cnt, next_chr_cnt;

   assign nb      = bit_order_select ? {pin_s.rxd, rx_sh[7:1]} : {rx_sh[6:0], pin_s.rxd};
   assign buf_exp = buffer_gap_timer_enable & buf_act & (buf_cnt >= buffer_gap_limit);
   assign chr_exp = char_gap_timer_enable & (pack_cnt != '0) & (chr_cnt >= char_gap_limit);
   // A bit sampled this cycle defers the flush by one cycle rather than racing it
   assign flush   = run & (buf_exp | chr_exp) & ~rx_sample; // RQ11 RQ12

   // Bytes gather little-end first; a word leaves only when full or flushed
   always_comb begin
      next_rx_sh    = rx_sh;
      next_rx_bits  = rx_bits;
      next_pack     = pack;
      next_pack_cnt = pack_cnt;
      byte_done     = 1'b0;
      rx_push       = 1'b0;
      push_entry    = '{count: pack_cnt, data: pack};
      if (!run) begin
         next_rx_bits  = '0;
         next_pack     = '0;
         next_pack_cnt = '0;
      end else if (rx_sample) begin
         next_rx_sh   = nb;
         next_rx_bits = rx_bits + 3'h1;
         if (rx_bits == 3'h7) begin
            byte_done = 1'b1;
            next_pack[8*pack_cnt +: 8] = nb;
            if (pack_cnt == 3'(BYTES_PER_WORD - 1)) begin
               rx_push       = 1'b1;     // RQ20
               push_entry    = '{count: MAX_BYTES, data: next_pack};
               next_pack     = '0;
               next_pack_cnt = '0;
            end else begin
               next_pack_cnt = pack_cnt + 3'h1;
            end
         end
      end else if (flush && pack_cnt != '0) begin
         rx_push       = 1'b1;           // RQ21
         next_pack     = '0;
         next_pack_cnt = '0;
      end
   end

   // Buffer timer runs from the first byte; character timer restarts on each byte
   always_comb begin
      next_buf_act = buf_act | byte_done;
      next_buf_cnt = (buf_act && buf_cnt != '1) ? buf_cnt + GAP_W'(1) : buf_cnt; // RQ11
      next_chr_cnt = byte_done ? '0
                     : (chr_cnt != '1) ? chr_cnt + GAP_W'(1) : chr_cnt;        // RQ12
      if (!run || flush) begin
         next_buf_act = 1'b0;
         next_buf_cnt = '0;
         next_chr_cnt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_sh    <= '0;
         rx_bits  <= '0;
         pack     <= '0;
         pack_cnt <= '0;
         buf_act  <= 1'b0;
         buf_cnt  <= '0;
         chr_cnt  <= '0;
      end else begin
         rx_sh    <= next_rx_sh;
         rx_bits  <= next_rx_bits;
         pack     <= next_pack;
         pack_cnt <= next_pack_cnt;
         buf_act  <= next_buf_act;
         buf_cnt  <= next_buf_cnt;
         chr_cnt  <= next_chr_cnt;
      end
   end

   // ---------------- Receive FIFO and processor side status ----------------
   rx_entry_t         rx_mem [RXF_DEPTH];
   logic [RXF_AW-1:0] rx_wp, rx_rp, next_rx_wp, next_rx_rp;
   logic [RXF_CW-1:0] rx_cnt, next_rx_cnt, cnt_left;
   logic              rx_pop, do_push, next_closed, next_ready;
   logic [2:0]        next_vbc;
   logic [31:0]       next_rx_data;

   // Reads are refused while the closed flag waits for its acknowledge
   assign rx_pop  = rx_read & (rx_cnt != '0) & ~rx_buffer_closed; // RQ3 RQ24
   // A full FIFO drops the incoming word
   assign do_push = rx_push & (rx_cnt != RXF_CW'(RXF_DEPTH));

   always_comb begin
      next_rx_wp   = rx_wp + RXF_AW'(do_push);
      next_rx_rp   = rx_rp + RXF_AW'(rx_pop);
      next_rx_cnt  = rx_cnt + RXF_CW'(do_push) - RXF_CW'(rx_pop);
      cnt_left     = rx_cnt - RXF_CW'(rx_pop);
      next_rx_data = rx_pop ? rx_mem[rx_rp].data : rx_data; // RQ1
      // Closing set wins over an acknowledge in the same cycle
      next_closed  = flush | (rx_buffer_closed & ~closed_ack); // RQ3
      if (!run) begin
         next_rx_wp  = '0;
         next_rx_rp  = '0;
         next_rx_cnt = '0;
         next_closed = 1'b0;
      end
      if (next_rx_cnt == '0) begin
         next_vbc = '0;
      end else if (cnt_left == '0) begin
         next_vbc = push_entry.count;
      end else begin
         next_vbc = rx_mem[next_rx_rp].count;   // RQ2
      end
      next_ready = (next_rx_cnt != '0) & ~next_closed;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_wp               <= '0;
         rx_rp               <= '0;
         rx_cnt              <= '0;
         rx_data             <= '0;
         rx_buffer_closed    <= 1'b0;
         rx_ready_flag       <= 1'b0;
         rx_valid_byte_count <= '0;
         rx_irq              <= 1'b0;
         rx_dma_req          <= 1'b0;
      end else begin
         rx_wp               <= next_rx_wp;
         rx_rp               <= next_rx_rp;
         rx_cnt              <= next_rx_cnt;
         rx_data             <= next_rx_data;
         rx_buffer_closed    <= next_closed;
         rx_ready_flag       <= next_ready;
         rx_valid_byte_count <= next_vbc;
         rx_irq              <= chan_rx_global_irq_en &
                                ((rx_ready_irq_enable & next_ready) |
                                 (rx_closed_irq_enable & next_closed)); // RQ4
         rx_dma_req          <= rx_dma_enable & next_ready;             // RQ5
      end
   end

   always_ff @(posedge core_clk) begin
      if (do_push) begin
         rx_mem[rx_wp] <= push_entry;
      end
   end

   // ---------------- Checks ----------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_mst_rise_sel;
      is_mst && $rose(sclk_out) |-> !sel_b_out;
   endproperty
   a_mst_rise_sel: assert property (p_mst_rise_sel) else $error("clock rose with select high"); // RQ15

   property p_sel_fall;
      is_mst && $past(is_mst) && $fell(sel_b_out) |-> $fell(sclk_out) && !$stable(lstate);
   endproperty
   a_sel_fall: assert property (p_sel_fall) else $error("select fell off a falling clock"); // RQ14

   property p_txd_on_fall;
      is_mst && $past(is_mst) && $changed(txd_out) |-> $fell(sclk_out);
   endproperty
   a_txd_on_fall: assert property (p_txd_on_fall) else $error("master data moved off falling clock"); // RQ13

   property p_mst_start;
      is_mst && lstate == M_IDLE && tx_has |-> ##[1:5] (!sel_b_out || !is_mst);
   endproperty
   a_mst_start: assert property (p_mst_start) else $error("master idle with data queued"); // RQ16

   property p_sample_rise;
      rx_sample && is_mst |=> $rose(sclk_out);
   endproperty
   a_sample_rise: assert property (p_sample_rise) else $error("master sampled off rising clock"); // RQ17

   property p_slv_sample;
      is_slv && !pin_s.sel_b && $past(!pin_s.sel_b) && $rose(spi_in.sclk)
         |-> ##3 rx_sample;
   endproperty
   a_slv_sample: assert property (p_slv_sample) else $error("slave sample not 3-4 clocks late"); // RQ18

   property p_full_word;
      rx_push && !flush |-> push_entry.count == MAX_BYTES;
   endproperty
   a_full_word: assert property (p_full_word) else $error("partial word pushed without flush"); // RQ20

   property p_flush_push;
      flush && pack_cnt != '0 |-> rx_push ##1 pack_cnt == '0;
   endproperty
   a_flush_push: assert property (p_flush_push) else $error("residual bytes not pushed"); // RQ21

   property p_closed_blocks;
      rx_buffer_closed && rx_read |=> $stable(rx_data) && $stable(rx_rp);
   endproperty
   a_closed_blocks: assert property (p_closed_blocks) else $error("read taken while closed"); // RQ3

   property p_pop_advance;
      rx_pop && !do_push && run |=> rx_cnt == $past(rx_cnt) - 1;
   endproperty
   a_pop_advance: assert property (p_pop_advance) else $error("read did not advance one word"); // RQ24

   property p_irq_gate;
      !chan_rx_global_irq_en |=> !rx_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without global enable"); // RQ4

   property p_vbc_range;
      rx_ready_flag |-> rx_valid_byte_count inside {[3'h1:3'h4]};
   endproperty
   a_vbc_range: assert property (p_vbc_range) else $error("bad valid byte count"); // RQ2

   property p_slv_hold;
      is_slv && $past(is_slv) && pin_s.sel_b && $past(pin_s.sel_b) && !$past(sl_need)
         |-> $stable(txd_out);
   endproperty
   a_slv_hold: assert property (p_slv_hold) else $error("slave data moved while deselected"); // RQ25

   c_word_push: cover property (rx_push && push_entry.count == MAX_BYTES);
   c_flush: cover property (flush && pack_cnt != '0);
   c_ack: cover property (rx_buffer_closed && closed_ack);
   c_mst_byte: cover property (is_mst && $rose(sel_b_out));
endmodule // spi_serial_channel

// *** test/spi_slave_model.sv ***
// Behavioural SPI slave device answering the channel in master mode
`timescale 1ns/100ps
module spi_slave_model (
   input  wire logic       sclk,
   input  wire logic       sel_b,
   input  wire logic       txd,
   output logic            rxd,
   output logic [7:0]      got,
   output logic            got_stb
);
   logic [7:0] sh_in;
   logic [7:0] sh_out;
   int         nbit = 0;
   int         k = 0;

   initial begin
      rxd = 1'b1;
      got_stb = 1'b0;
   end
   // Reply byte loads as select falls, first bit valid before the first rise
   always @(negedge sel_b) begin
      sh_out = 8'hA0 + k[7:0];
      rxd = sh_out[7];
      nbit = 0;
   end
   // Sample on the rising clock, most significant bit first
   always @(posedge sclk) if (!sel_b) begin
      sh_in = {sh_in[6:0], txd};
      nbit++;
      if (nbit == 8) begin
         got = sh_in;
         k++;
         got_stb = 1'b1;
         #1 got_stb = 1'b0;
      end
   end
   // Next reply bit on the falling clock
   always @(negedge sclk) if (!sel_b && nbit > 0 && nbit < 8) rxd = sh_out[7 - nbit];
   // Released line shows the inverse, so a late sample never matches by luck
   always @(posedge sel_b) rxd = ~rxd;
endmodule // spi_slave_model

// *** test/tb.sv ***
// Self-checking bench: SPI channel in master mode against a slave model, then a slave-mode idle check
`timescale 1ns/100ps
module tb;
   import spi_chan_pkg::*;
   logic        core_clk = 0, rst_b = 0, chan_enable = 0, tx_valid = 0, rx_read = 0;
   logic        rx_ready_irq_enable = 0, rx_closed_irq_enable = 0, chan_rx_global_irq_en = 0;
   logic        rx_dma_enable = 0, buffer_gap_timer_enable = 0, char_gap_timer_enable = 0;
   logic        closed_ack = 0, pend = 0;
   logic [1:0]  mode = MODE_MASTER;
   logic [7:0]  tx_byte = 8'h00;
   logic        tx_ready, rx_ready_flag, rx_buffer_closed, rx_irq, rx_dma_req, rxd_m, got_stb;
   logic        sclk_out, sclk_oe, sel_b_out, sel_b_oe, txd_out, txd_oe;
   logic [31:0] rx_data, old;
   logic [31:0] seed = 32'h6288;
   logic [2:0]  rx_valid_byte_count;
   logic [7:0]  got;
   logic [7:0]  exp_tx[$];
   logic [31:0] exp_rx[$];
   int          err_total = 0, cmp_count = 0;
   spi_in_t     spi_in;

   assign spi_in = '{sclk: sclk_out, sel_b: sel_b_out, rxd: rxd_m};
   // Mode is set while the channel is off; master uses its own 1x divider timing
   spi_serial_channel u_spi_serial_channel (.core_clk, .rst_b, .chan_enable,
      .mode, .word_length_select(WLS_8BIT), .bit_order_select(1'b0),
      .rx_ready_irq_enable, .rx_closed_irq_enable, .chan_rx_global_irq_en, .rx_dma_enable,
      .buffer_gap_timer_enable, .char_gap_timer_enable, .buffer_gap_limit(16'h0190),
      .char_gap_limit(16'h012C), .tx_valid, .tx_byte, .rx_read, .closed_ack, .spi_in,
      .tx_ready, .rx_data, .rx_ready_flag, .rx_valid_byte_count, .rx_buffer_closed, .rx_irq,
      .rx_dma_req, .sclk_out, .sclk_oe, .sel_b_out, .sel_b_oe, .txd_out, .txd_oe);
   spi_slave_model u_spi_slave_model (.sclk(sclk_out), .sel_b(sel_b_out), .txd(txd_out),
      .rxd(rxd_m), .got, .got_stb);

   initial forever #12.5 core_clk = ~core_clk;

   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // Expected word: reply bytes numbered from f, first byte lowest, unused bytes zero
   function automatic logic [31:0] w(input int f, input int n);
      logic [31:0] r = 32'h0;
      for (int i = 0; i < n; i++) r[8*i +: 8] = 8'hA0 + f[7:0] + i[7:0];
      return r;
   endfunction
   function automatic logic pick(input int s);
      return s == 0 ? tx_ready : s == 1 ? rx_ready_flag : rx_buffer_closed;
   endfunction
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("Error %0t: %s", $time, m);
      end
   endtask
   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait, so a stuck flag ends the run instead of hanging it
   task automatic wait_hi(input int s);
      int i;
      for (i = 0; i < 4000 && pick(s) !== 1'b1; i++) @(posedge core_clk);
      if (i == 4000) begin
         err_total++;
         $display("Error %0t: wait timed out", $time);
         conclude();
      end
   endtask
   // Back-to-back pushes; valid stays up between bytes
   task automatic send(input int n);
      logic [7:0] b;
      int j;
      for (int k = 0; k < n; k++) begin
         b = xs();
         exp_tx.push_back(b);
         tx_valid <= 1'b1;
         tx_byte <= b;
         for (j = 0; j < 100; j++) begin
            @(posedge core_clk);
            if (tx_ready === 1'b1) break;
         end
         chk(j < 100, "push refused");
         if (j == 100) conclude();
      end
      tx_valid <= 1'b0;
   endtask
   task automatic rd(input int f, input int n);
      wait_hi(1);
      chk(rx_valid_byte_count === n[2:0], "valid byte count");
      exp_rx.push_back(w(f, n));
      rx_read <= 1'b1;
      @(posedge core_clk);
      rx_read <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic ack();
      closed_ack <= 1'b1;
      @(posedge core_clk);
      closed_ack <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   // Watchers take the oldest note whenever a result shows
   always @(posedge core_clk) pend <= rx_read & rx_ready_flag;
   always @(negedge core_clk) if (pend) chk(rx_data === exp_rx.pop_front(), "rx word");
   always @(posedge got_stb) chk(got === exp_tx.pop_front(), "byte at slave");
   always @(posedge sclk_out) if (rst_b) chk(sel_b_out === 1'b0, "clock rose deselected");

   initial begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk(sel_b_out === 1'b1 && tx_ready === 1'b0, "idle after reset");
      chan_enable <= 1'b1;
      wait_hi(0);
      send(8);
      rd(0, 4);
      rd(4, 4);
      $display("test 1 done: whole words");
      char_gap_timer_enable <= 1'b1;
      rx_closed_irq_enable <= 1'b1;
      chan_rx_global_irq_en <= 1'b1;
      send(3);
      wait_hi(2);
      chk(rx_valid_byte_count === 3'h3 && rx_irq === 1'b1, "char gap flush");
      old = rx_data;
      rx_read <= 1'b1;
      @(posedge core_clk);
      rx_read <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(rx_data === old && rx_buffer_closed === 1'b1, "read while closed");
      ack();
      chk(rx_ready_flag === 1'b1 && rx_irq === 1'b0, "closed ack");
      char_gap_timer_enable <= 1'b0;
      rd(8, 3);
      $display("test 2 done: character gap");
      buffer_gap_timer_enable <= 1'b1;
      rx_dma_enable <= 1'b1;
      send(1);
      wait_hi(2);
      ack();
      chk(rx_dma_req === 1'b1 && rx_valid_byte_count === 3'h1, "buffer gap");
      rd(11, 1);
      repeat (4) @(posedge core_clk);
      chk(exp_tx.size() == 0 && exp_rx.size() == 0, "results missing");
      $display("test 3 done: buffer gap");
      chan_enable <= 1'b0;
      mode <= MODE_SLAVE;
      repeat (2) @(posedge core_clk);
      chk(tx_ready === 1'b0 && sclk_oe === 1'b0 && sel_b_oe === 1'b0, "channel reset");
      chan_enable <= 1'b1;
      wait_hi(0);
      send(1);
      old[7:0] = exp_tx.pop_front();
      repeat (3) @(posedge core_clk);
      chk(txd_out === old[7] && txd_oe === 1'b1, "slave first bit");
      repeat (8) @(posedge core_clk);
      chk(txd_out === old[7], "slave held while deselected");
      $display("test 4 done: slave idle");
      conclude();
   end
endmodule // tb
